// file: verilog/rwd_pkg.sv
// Constants, field layouts and state carriers for the reset and watchdog block.
// Assumes a 40 MHz system clock and a free-running 128 kHz watchdog oscillator pin.
package rwd_pkg;

    localparam int CLK_MHZ              = 40;
    localparam int WDT_OSC_KHZ          = 128;
    localparam int EXT_MIN_PULSE_NS     = 2000;
    localparam int BOD_MIN_NS           = 2000;
    localparam int STARTUP_DELAY_US     = 4000;
    localparam int STARTUP_DELAY_CYC_DEF = STARTUP_DELAY_US * CLK_MHZ;
    localparam int STARTUP_CNT_W        = 24;
    localparam int FILT_W               = 8;
    localparam int WIN_W                = 3;
    localparam logic [WIN_W-1:0] WINDOW_CYCLES = 3'h4;

    localparam int WDT_CNT_W            = 20;
    localparam logic [20:0] WDT_BASE_CYCLES = 21'h000800;
    localparam logic [3:0] WDT_PRESC_MAX = 4'h9;

    localparam logic [2:0] BOD_FUSE_OFF = 3'h7;

    localparam int ADDR_W               = 4;
    localparam int DATA_W               = 32;
    localparam logic [ADDR_W-1:0] OFS_WDG_CTRL  = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_RST_FLAGS = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_STATUS    = 4'h8;

    // Rounds a least time up to whole cycles, never below one
    function automatic int ns_to_cycles(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    // Terminal count for a prescale code
    function automatic logic [WDT_CNT_W-1:0] wdt_terminal(input logic [3:0] code);
        logic [3:0] c;
        c = (code > WDT_PRESC_MAX) ? WDT_PRESC_MAX : code;
        return WDT_CNT_W'((WDT_BASE_CYCLES << c) - 21'h000001);
    endfunction

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } rwd_bus_e;

    typedef struct packed {
        logic       irq_flag;
        logic       irq_en;
        logic       presc_hi;
        logic       chg_en;
        logic       wdg_en;
        logic [2:0] presc_lo;
    } rwd_ctrl_s;

    typedef struct packed {
        logic [3:0] rsvd;
        logic       wdt;
        logic       brownout_detector;
        logic       ext;
        logic       por;
    } rwd_flags_s;

    typedef struct packed {
        logic [WDT_CNT_W-1:0] cnt;
        logic                 expired;
    } rwd_cnt_s;

    typedef struct packed {
        rwd_bus_e               bus;
        logic                   wait_r;
        logic [DATA_W-1:0]      rdata;
        logic [1:0]             por_sync;
        logic [1:0]             ext_sync;
        logic [1:0]             bod_sync;
        logic [1:0]             osc_sync;
        logic                   osc_prev;
        logic [FILT_W-1:0]      ext_cnt;
        logic [FILT_W-1:0]      bod_cnt;
        logic                   ext_act;
        logic                   bod_act;
        logic                   wdt_pulse;
        logic [STARTUP_CNT_W-1:0] dly_cnt;
        logic                   chip_rst;
        rwd_ctrl_s              ctrl;
        logic [WIN_W-1:0]       win_cnt;
        rwd_flags_s             flags;
        logic                   bandgap;
    } rwd_state_s;

endpackage

// file: verilog/rwd_wdt_counter.sv
// Watchdog period counter, advanced by synchronised oscillator ticks.
// Assumes tick is a one-cycle pulse in the system clock domain.
`timescale 1ns/1ps
module rwd_wdt_counter
    import rwd_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_ce,
    input  wire logic       i_clear,
    input  wire logic       i_tick,
    input  wire logic [3:0] i_presc,
    output logic            o_expired
);

    rwd_cnt_s s;
    rwd_cnt_s next_s;

    always_comb
    begin
        next_s = s;
        if (i_ce)
        begin
            next_s.expired = 1'b0;
            if (i_clear)
            begin
                next_s.cnt = '0;
            end
            else if (i_tick)
            begin
                // Compare against terminal so a shortened period takes effect at once
                if (s.cnt >= wdt_terminal(i_presc))
                begin
                    next_s.cnt     = '0;
                    next_s.expired = 1'b1;
                end
                else
                begin
                    next_s.cnt = s.cnt + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign o_expired = s.expired;

endmodule

// file: verilog/rwd_reset_watchdog.sv
// Reset source combiner, start-up delay stretcher and watchdog with timed configuration.
// Assumes analog detector outputs and the oscillator arrive asynchronously; the
// restart strobe, acknowledge and straps come from logic on I_CLK.
//
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/1ps
module rwd_reset_watchdog
    import rwd_pkg::*;
#(
    parameter int STARTUP_DELAY_CYCLES = STARTUP_DELAY_CYC_DEF
)
(
    input  wire logic              I_CLK,
    input  wire logic              I_SYS_RST,
    input  wire logic              I_CE,
    input  wire logic [ADDR_W-1:0] I_AVS_ADDRESS,
    input  wire logic              I_AVS_READ,
    input  wire logic              I_AVS_WRITE,
    input  wire logic [DATA_W-1:0] I_AVS_WRITEDATA,
    input  wire logic [3:0]        I_AVS_BYTEENABLE,
    output logic [DATA_W-1:0]      O_AVS_READDATA,
    output logic                   O_AVS_WAITREQUEST,
    input  wire logic              I_SUPPLY_OK,
    input  wire logic              I_EXT_RST_N,
    input  wire logic              I_EXT_RST_EN,
    input  wire logic              I_BROWNOUT_LOW,
    input  wire logic [2:0]        I_BROWNOUT_LEVEL_FUSE,
    input  wire logic              I_SAFETY_LEVEL_FUSE,
    input  wire logic              I_COMPARATOR_BANDGAP_SELECT,
    input  wire logic              I_ADC_ENABLE,
    input  wire logic              I_WDT_OSC,
    input  wire logic              I_WATCHDOG_RESTART_INSTRUCTION,
    input  wire logic              I_WDT_IRQ_ACK,
    output logic                   O_CHIP_RST,
    output logic                   O_WDT_IRQ,
    output logic                   O_BANDGAP_ENABLE
);

    localparam logic [FILT_W-1:0] EXT_CYC = FILT_W'(ns_to_cycles(EXT_MIN_PULSE_NS));
    localparam logic [FILT_W-1:0] BOD_CYC = FILT_W'(ns_to_cycles(BOD_MIN_NS));
    localparam logic [STARTUP_CNT_W-1:0] DLY_LOAD = STARTUP_CNT_W'(STARTUP_DELAY_CYCLES);

    if (STARTUP_DELAY_CYCLES < 1 || STARTUP_DELAY_CYCLES >= (1 << STARTUP_CNT_W))
    begin : g_chk_dly
        $error("STARTUP_DELAY_CYCLES out of range");
    end
    if (ns_to_cycles(EXT_MIN_PULSE_NS) >= (1 << FILT_W) || ns_to_cycles(BOD_MIN_NS) >= (1 << FILT_W))
    begin : g_chk_filt
        $error("Filter length exceeds counter width");
    end

    ////////////////////////////////////////////////////////////////////////////////

    rwd_state_s s;
    rwd_state_s next_s;

    logic       level2;
    logic       en_eff;
    logic       wdg_run;
    logic       win_open;
    logic       bod_en;
    logic       osc_tick;
    logic       expired;
    logic       cnt_clear;
    logic [3:0] presc;

    always_comb
    begin
        level2   = I_SAFETY_LEVEL_FUSE;
        // Level 1 keeps the watchdog on while the watchdog reset flag stays set
        en_eff   = s.ctrl.wdg_en | level2 | s.flags.wdt;
        wdg_run  = en_eff | s.ctrl.irq_en;
        win_open = (s.win_cnt != '0);
        bod_en   = (I_BROWNOUT_LEVEL_FUSE != BOD_FUSE_OFF);
        osc_tick = s.osc_sync[1] & ~s.osc_prev;
        presc    = {s.ctrl.presc_hi, s.ctrl.presc_lo};
        cnt_clear = s.chip_rst | ~wdg_run | I_WATCHDOG_RESTART_INSTRUCTION;
    end

    rwd_wdt_counter u_counter
    (
        .i_clk     (I_CLK),
        .i_rst     (I_SYS_RST),
        .i_ce      (I_CE),
        .i_clear   (cnt_clear),
        .i_tick    (osc_tick),
        .i_presc   (presc),
        .o_expired (expired)
    );

    ////////////////////////////////////////////////////////////////////////////////

    function automatic logic [DATA_W-1:0] read_word(input rwd_state_s st,
                                                    input logic [ADDR_W-1:0] addr,
                                                    input logic en, input logic open,
                                                    input logic lvl2, input logic run);
        rwd_ctrl_s c;
        c        = st.ctrl;
        c.chg_en = open;
        c.wdg_en = en;
        if (addr == OFS_WDG_CTRL)
        begin
            return {24'h000000, c};
        end
        else if (addr == OFS_RST_FLAGS)
        begin
            return {24'h000000, 4'h0, st.flags[3:0]};
        end
        else if (addr == OFS_STATUS)
        begin
            return {28'h0000000, run, open, lvl2, st.bandgap};
        end
        else
        begin
            return '0;
        end
    endfunction

    rwd_ctrl_s  w_ctrl;
    rwd_flags_s w_flags;
    logic       acc_wr;
    logic       src_any;

    always_comb
    begin
        next_s  = s;
        w_ctrl  = rwd_ctrl_s'(I_AVS_WRITEDATA[7:0]);
        w_flags = rwd_flags_s'(I_AVS_WRITEDATA[7:0]);
        acc_wr  = (s.bus == BUS_ACK) && I_AVS_WRITE && I_AVS_BYTEENABLE[0];
        src_any = 1'b0;
        if (I_CE)
        begin
            // Detector inputs: two flops before anything looks at them
            next_s.por_sync = {s.por_sync[0], I_SUPPLY_OK};
            next_s.ext_sync = {s.ext_sync[0], I_EXT_RST_N};
            next_s.bod_sync = {s.bod_sync[0], I_BROWNOUT_LOW};
            next_s.osc_sync = {s.osc_sync[0], I_WDT_OSC};
            next_s.osc_prev = s.osc_sync[1];

            // External pin filter; shorter pulses never reach the combiner
            if (!(I_EXT_RST_EN && !s.ext_sync[1]))
            begin
                next_s.ext_cnt = '0;
                next_s.ext_act = 1'b0;
            end
            else if (s.ext_cnt == EXT_CYC)
            begin
                next_s.ext_act = 1'b1;
            end
            else
            begin
                next_s.ext_cnt = s.ext_cnt + 1'b1;
            end

            if (!(bod_en && s.bod_sync[1]))
            begin
                next_s.bod_cnt = '0;
                next_s.bod_act = 1'b0;
            end
            else if (s.bod_cnt == BOD_CYC)
            begin
                next_s.bod_act = 1'b1;
            end
            else
            begin
                next_s.bod_cnt = s.bod_cnt + 1'b1;
            end

            // Combiner and start-up stretch
            src_any = ~s.por_sync[1] | s.ext_act | s.bod_act | s.wdt_pulse;
            if (src_any)
            begin
                next_s.dly_cnt = DLY_LOAD;
            end
            else if (s.dly_cnt != '0)
            begin
                next_s.dly_cnt = s.dly_cnt - 1'b1;
            end
            next_s.chip_rst  = src_any | (s.dly_cnt != '0);
            next_s.wdt_pulse = 1'b0;
            next_s.bandgap   = bod_en | I_COMPARATOR_BANDGAP_SELECT | I_ADC_ENABLE;

            if (s.win_cnt != '0)
            begin
                next_s.win_cnt = s.win_cnt - 1'b1;
            end

            // Software writes first, hardware events after so that a set wins
            if (acc_wr && I_AVS_ADDRESS == OFS_RST_FLAGS)
            begin
                next_s.flags[3:0] = s.flags[3:0] & w_flags[3:0];
            end
            if (I_WDT_IRQ_ACK)
            begin
                next_s.ctrl.irq_flag = 1'b0;
            end
            if (acc_wr && I_AVS_ADDRESS == OFS_WDG_CTRL)
            begin
                next_s.ctrl.irq_en = w_ctrl.irq_en;
                if (w_ctrl.irq_flag)
                begin
                    next_s.ctrl.irq_flag = 1'b0;
                end
                if (w_ctrl.chg_en && w_ctrl.wdg_en)
                begin
                    next_s.win_cnt = WINDOW_CYCLES;
                    if (!level2)
                    begin
                        next_s.ctrl.wdg_en   = 1'b1;
                        next_s.ctrl.presc_hi = w_ctrl.presc_hi;
                        next_s.ctrl.presc_lo = w_ctrl.presc_lo;
                    end
                end
                else if (win_open && !w_ctrl.chg_en)
                begin
                    next_s.win_cnt       = '0;
                    next_s.ctrl.presc_hi = w_ctrl.presc_hi;
                    next_s.ctrl.presc_lo = w_ctrl.presc_lo;
                    if (!level2)
                    begin
                        next_s.ctrl.wdg_en = w_ctrl.wdg_en;
                    end
                end
                else if (!level2)
                begin
                    // Level 1 changes the period freely but cannot clear enable here
                    next_s.ctrl.presc_hi = w_ctrl.presc_hi;
                    next_s.ctrl.presc_lo = w_ctrl.presc_lo;
                    if (w_ctrl.wdg_en)
                    begin
                        next_s.ctrl.wdg_en = 1'b1;
                    end
                end
            end

            // Time-out action
            if (expired && !s.chip_rst)
            begin
                if (s.ctrl.irq_en)
                begin
                    next_s.ctrl.irq_flag = 1'b1;
                    if (en_eff)
                    begin
                        next_s.ctrl.irq_en = 1'b0;
                    end
                end
                else if (en_eff)
                begin
                    next_s.wdt_pulse = 1'b1;
                end
            end

            // Cause flags; power-on wipes the others
            if (!s.por_sync[1])
            begin
                next_s.flags[3:0] = 4'h1;
            end
            else
            begin
                if (s.ext_act)
                begin
                    next_s.flags.ext = 1'b1;
                end
                if (s.bod_act)
                begin
                    next_s.flags.brownout_detector = 1'b1;
                end
                if (s.wdt_pulse)
                begin
                    next_s.flags.wdt = 1'b1;
                end
            end

            // Chip reset returns the watchdog control to its initial state
            if (s.chip_rst)
            begin
                next_s.ctrl    = '0;
                next_s.win_cnt = '0;
            end

            // Bus slave: one wait cycle, then a single accepting cycle
            case (s.bus)
                BUS_IDLE:
                begin
                    if (I_AVS_READ || I_AVS_WRITE)
                    begin
                        next_s.bus    = BUS_ACK;
                        next_s.wait_r = 1'b0;
                        next_s.rdata  = I_AVS_READ ? read_word(s, I_AVS_ADDRESS, en_eff, win_open, level2, wdg_run)
                                                   : '0;
                    end
                end
                BUS_ACK:
                begin
                    next_s.bus    = BUS_IDLE;
                    next_s.wait_r = 1'b1;
                end
                default:
                begin
                    next_s.bus    = BUS_IDLE;
                    next_s.wait_r = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            s          <= '0;
            s.bus      <= BUS_IDLE;
            s.wait_r   <= 1'b1;
            s.chip_rst <= 1'b1;
            s.dly_cnt  <= DLY_LOAD;
        end
        else
        begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    // Registered outputs; no path from a pin reaches them without a clock
    assign O_AVS_READDATA    = s.rdata;
    assign O_AVS_WAITREQUEST = s.wait_r;
    assign O_CHIP_RST        = s.chip_rst;
    assign O_WDT_IRQ         = s.ctrl.irq_flag;
    assign O_BANDGAP_ENABLE  = s.bandgap;

endmodule

// file: bench/rwd_reset_watchdog_sva.sv
// Port-level checker for the reset and watchdog block.
// Assumes a bind into rwd_reset_watchdog with I_CE held high by the bench.
`timescale 1ns/1ps
module rwd_reset_watchdog_sva
    import rwd_pkg::*;
#(
    parameter int STARTUP_DELAY_CYCLES = STARTUP_DELAY_CYC_DEF
)
(
    input wire logic              I_CLK,
    input wire logic              I_SYS_RST,
    input wire logic              I_CE,
    input wire logic              I_AVS_WRITE,
    input wire logic [DATA_W-1:0] O_AVS_READDATA,
    input wire logic              O_AVS_WAITREQUEST,
    input wire logic              I_SUPPLY_OK,
    input wire logic              I_EXT_RST_N,
    input wire logic              I_EXT_RST_EN,
    input wire logic              I_BROWNOUT_LOW,
    input wire logic [2:0]        I_BROWNOUT_LEVEL_FUSE,
    input wire logic              I_COMPARATOR_BANDGAP_SELECT,
    input wire logic              I_ADC_ENABLE,
    input wire logic              I_WDT_IRQ_ACK,
    input wire logic              O_CHIP_RST,
    input wire logic              O_WDT_IRQ,
    input wire logic              O_BANDGAP_ENABLE
);
    ////////////////////////////////////////////////////////////////////////////////
    int unsigned hi_cnt, ext_cnt, bod_cnt;
    // Run lengths of each level; counters avoid long repetitions in the properties
    always_ff @(posedge I_CLK)
    begin
        hi_cnt  <= (I_SYS_RST || !O_CHIP_RST) ? 0 : hi_cnt + 1;
        ext_cnt <= (I_SYS_RST || I_EXT_RST_N || !I_EXT_RST_EN) ? 0 : ext_cnt + 1;
        bod_cnt <= (I_SYS_RST || !I_BROWNOUT_LOW || I_BROWNOUT_LEVEL_FUSE == BOD_FUSE_OFF) ? 0 : bod_cnt + 1;
    end
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_SYS_RST);
    ////////////////////////////////////////////////////////////////////////////////
    stretch_min_a: assert property ($fell(O_CHIP_RST) |-> hi_cnt >= STARTUP_DELAY_CYCLES)
        else $error("chip reset released before the start-up delay");
    release_supply_a: assert property ($fell(O_CHIP_RST) |-> $past(I_SUPPLY_OK))
        else $error("chip reset released with supply low");
    por_drop_a: assert property (!I_SUPPLY_OK |-> ##[0:4] O_CHIP_RST)
        else $error("supply drop did not reset the chip at once");
    ext_low_a: assert property (ext_cnt == 88 |-> O_CHIP_RST)
        else $error("long pin low did not reset the chip");
    bod_low_a: assert property (bod_cnt == 88 |-> O_CHIP_RST)
        else $error("long brown-out did not reset the chip");
    bandgap_or_a: assert property ($past(I_CE) && !$past(I_SYS_RST) |-> O_BANDGAP_ENABLE ==
        ($past(I_BROWNOUT_LEVEL_FUSE) != BOD_FUSE_OFF || $past(I_COMPARATOR_BANDGAP_SELECT) || $past(I_ADC_ENABLE)))
        else $error("bandgap enable differs from its sources");
    irq_hold_a: assert property (O_WDT_IRQ && !I_WDT_IRQ_ACK && !I_AVS_WRITE && !O_CHIP_RST |=> O_WDT_IRQ)
        else $error("interrupt flag dropped without a clear");
    irq_ack_a: assert property (I_WDT_IRQ_ACK |=> !O_WDT_IRQ)
        else $error("interrupt flag survived an acknowledge");
    wait_pulse_a: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
        else $error("waitrequest low for more than one cycle");
    rd_upper_a: assert property (!O_AVS_WAITREQUEST |-> O_AVS_READDATA[31:8] == 24'h000000)
        else $error("upper read data bits not zero");
    irq_seen_c: cover property ($rose(O_WDT_IRQ));
    wdt_rst_c: cover property ($rose(O_CHIP_RST) && I_SUPPLY_OK && I_EXT_RST_N);
    bod_rst_c: cover property (bod_cnt == 88);
    ext_rst_c: cover property (ext_cnt == 88);
endmodule
bind rwd_reset_watchdog rwd_reset_watchdog_sva #(.STARTUP_DELAY_CYCLES(STARTUP_DELAY_CYCLES)) u_sva (
    .I_CLK, .I_SYS_RST, .I_CE, .I_AVS_WRITE, .O_AVS_READDATA, .O_AVS_WAITREQUEST, .I_SUPPLY_OK,
    .I_EXT_RST_N, .I_EXT_RST_EN, .I_BROWNOUT_LOW, .I_BROWNOUT_LEVEL_FUSE, .I_COMPARATOR_BANDGAP_SELECT,
    .I_ADC_ENABLE, .I_WDT_IRQ_ACK, .O_CHIP_RST, .O_WDT_IRQ, .O_BANDGAP_ENABLE);

// file: bench/rwd_reset_watchdog_tb.sv
// Self-checking bench for the reset and watchdog block.
// Assumes one wait cycle per bus transfer and a shortened start-up delay.
`timescale 1ns/1ps
module rwd_reset_watchdog_tb;
    import rwd_pkg::*;
    localparam int DLY = 20;
    logic        clk = 0, rst = 1, rd = 0, wr = 0, sup = 1, ext_n = 1, ext_en = 1, bod_low = 0;
    logic        lvl2 = 0, comparator_bandgap_select = 0, adc = 0, osc = 0, watchdog_restart_instruction = 0, ack = 0;
    logic [3:0]  addr = 4'h0;
    logic [2:0]  bfuse = 3'h7;
    logic [31:0] wdata = 32'h0, rdata;
    logic        waitreq, chip_rst, irq, bg;
    logic [7:0]  q;
    int          n_mismatch = 0, tests_run = 0, seed = 40, cyc = 0, k, i, wt;
    rwd_reset_watchdog #(.STARTUP_DELAY_CYCLES(DLY)) DUT (
        .I_CLK(clk), .I_SYS_RST(rst), .I_CE(1'b1), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
        .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(4'hf), .O_AVS_READDATA(rdata),
        .O_AVS_WAITREQUEST(waitreq), .I_SUPPLY_OK(sup), .I_EXT_RST_N(ext_n), .I_EXT_RST_EN(ext_en),
        .I_BROWNOUT_LOW(bod_low), .I_BROWNOUT_LEVEL_FUSE(bfuse), .I_SAFETY_LEVEL_FUSE(lvl2),
        .I_COMPARATOR_BANDGAP_SELECT(comparator_bandgap_select), .I_ADC_ENABLE(adc), .I_WDT_OSC(osc),
        .I_WATCHDOG_RESTART_INSTRUCTION(watchdog_restart_instruction), .I_WDT_IRQ_ACK(ack), .O_CHIP_RST(chip_rst),
        .O_WDT_IRQ(irq), .O_BANDGAP_ENABLE(bg));
    ////////////////////////////////////////////////////////////////////////////////
    always #12.5 clk = ~clk;
    // Oscillator sped up to one tick per 8 clocks so that expiries fit the run
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc % 4 == 3)
            osc <= ~osc;
        if (cyc == 95000)
        begin
            n_mismatch++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic bg_exp(input logic [2:0] f, input logic a, input logic d);
        return f != 3'h7 || a || d;
    endfunction
    function automatic int exp_cyc(input int code);
        return (2048 << (code > 9 ? 9 : code)) * 8;
    endfunction
    task automatic chk1(input string what, input logic e, input logic s);
        tests_run++;
        if (s !== e)
        begin
            $display("[FAIL] %s expected %b seen %b", what, e, s);
            n_mismatch++;
        end
    endtask
    task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] s);
        tests_run++;
        if (s !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", what, e, s);
            n_mismatch++;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Leaves the request up so that a following transfer runs back to back
    task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d);
        rd    <= !w;
        wr    <= w;
        addr  <= a;
        wdata <= {24'h000000, d};
        @(posedge clk);
        while (waitreq !== 1'b0)
            @(posedge clk);
        q = rdata[7:0];
    endtask
    // Lets one edge pass so that a following request never reassigns a strobe in the same step
    task automatic idle();
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e, input string what);
        xfer(1'b0, a, 8'h00);
        idle();
        chk8(what, e, q);
    endtask
    task automatic wr1(input logic [3:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
        idle();
    endtask
    task automatic wr2(input logic [7:0] d0, input logic [7:0] d1);
        xfer(1'b1, 4'h0, d0);
        xfer(1'b1, 4'h0, d1);
        idle();
    endtask
    // Detection lags the rise by up to one edge, hence the slack of one
    task automatic wait_fall();
        k = 0;
        while (chip_rst !== 1'b0)
        begin
            @(posedge clk);
            k++;
        end
        chk1("stretch", 1'b1, k >= DLY - 1);
    endtask
    task automatic do_reset();
        rst <= 1'b1;
        tick(4);
        chk1("rst_wait", 1'b1, waitreq);
        chk1("rst_chip", 1'b1, chip_rst);
        rst <= 1'b0;
        wait_fall();
    endtask
    task automatic close_out();
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        do_reset();
        for (i = 0; i < 8; i++)
        begin
            bfuse <= i[2] ? 3'h7 : 3'($unsigned($random(seed)) % 7);
            comparator_bandgap_select  <= i[1];
            adc   <= i[0];
            tick(3);
            chk1("bandgap", bg_exp(bfuse, comparator_bandgap_select, adc), bg);
        end
        bfuse   <= 3'h2;
        bod_low <= 1'b1;
        tick(10 + ($unsigned($random(seed)) % 40));
        bod_low <= 1'b0;
        tick(10);
        chk1("bod_dip", 1'b0, chip_rst);
        bod_low <= 1'b1;
        tick(100);
        chk1("bod_rst", 1'b1, chip_rst);
        bod_low <= 1'b0;
        wait_fall();
        ext_en <= 1'b0;
        ext_n  <= 1'b0;
        tick(100);
        chk1("ext_off", 1'b0, chip_rst);
        ext_en <= 1'b1;
        tick(100);
        chk1("ext_rst", 1'b1, chip_rst);
        ext_n <= 1'b1;
        wait_fall();
        sup <= 1'b0;
        tick(5);
        chk1("por_rst", 1'b1, chip_rst);
        sup <= 1'b1;
        wait_fall();
        rd_chk(4'h4, 8'h01, "flags_por");
        wr1(4'h4, 8'h00);
        wr1(4'hc, 8'($random(seed)));
        rd_chk(4'hc, 8'h00, "unmapped");
        rd_chk(4'h4, 8'h00, "flags_clr");
        wr1(4'h0, 8'h08);
        rd_chk(4'h0, 8'h08, "l1_on");
        wr1(4'h0, 8'h00);
        rd_chk(4'h0, 8'h08, "l1_nodis");
        wr2(8'h18, 8'h00);
        rd_chk(4'h0, 8'h00, "l1_dis");
        wr1(4'h0, 8'h18);
        tick(6);
        wr1(4'h0, 8'h00);
        rd_chk(4'h0, 8'h08, "l1_late");
        wr2(8'h18, 8'h00);
        wr1(4'h0, 8'h05);
        rd_chk(4'h0, 8'h05, "l1_presc");
        wt = exp_cyc(0);
        wr1(4'h0, 8'h40);
        tick(wt - 200);
        chk1("irq_early", 1'b0, irq);
        tick(400);
        chk1("irq_set", 1'b1, irq);
        chk1("irq_norst", 1'b0, chip_rst);
        ack <= 1'b1;
        tick(1);
        ack <= 1'b0;
        tick(2);
        chk1("irq_ack", 1'b0, irq);
        watchdog_restart_instruction <= 1'b1;
        wr1(4'h0, 8'h48);
        tick(wt + 500);
        chk1("restart", 1'b0, irq);
        watchdog_restart_instruction <= 1'b0;
        tick(wt - 200);
        chk1("irq_early2", 1'b0, irq);
        tick(400);
        chk1("irq_first", 1'b1, irq);
        rd_chk(4'h0, 8'h88, "ie_cleared");
        wr1(4'h0, 8'h88);
        chk1("irq_w1c", 1'b0, irq);
        tick(wt - 800);
        chk1("rst_early", 1'b0, chip_rst);
        k = 0;
        while (chip_rst !== 1'b1 && k < 1400)
        begin
            @(posedge clk);
            k++;
        end
        chk1("wdt_rst", 1'b1, chip_rst);
        wait_fall();
        rd_chk(4'h4, 8'h08, "flags_wdt");
        lvl2 <= 1'b1;
        do_reset();
        rd_chk(4'h0, 8'h08, "l2_on");
        wr2(8'h18, 8'h00);
        rd_chk(4'h0, 8'h08, "l2_nodis");
        wr2(8'h18, 8'h03);
        rd_chk(4'h0, 8'h0b, "l2_presc");
        wr1(4'h0, 8'h05);
        rd_chk(4'h0, 8'h0b, "l2_lock");
        rd_chk(4'h8, 8'h0b, "status");
        close_out();
    end
endmodule
